// file: src/serial_port.sv
// Serial port top: register slave, async transmitter, mode steering
`timescale 1ns/10ps
module serial_port import serial_port_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_timer1_ovf,
  output logic o_txd,
  input wire logic i_rxd,
  output logic o_rxd_out,
  output logic o_rxd_oe
);
  mode_t mode;
  logic multiproc_speed_select;
  logic rx_enable;
  logic rx_ninth_bit;
  logic tx_done_flag;
  logic rx_done_flag;
  logic rate_div32;
  logic [7:0] serial_data_buffer;
  logic ack;
  logic wr_ctrl;
  logic wr_data;
  logic wr_rate;
  logic [31:0] next_readdata;

  logic ovf_half;
  logic tick;
  logic [3:0] tx_cnt;
  logic rollover;
  logic tx_pend;
  logic tx_busy;
  logic [7:0] tx_hold;
  logic [7:0] tx_sr;
  logic [3:0] tx_bits;
  logic txd_bit;
  logic tx_async_done;

  logic sh_busy;
  logic sh_clk;
  logic sh_data;
  logic sh_oe;
  logic sh_done_tx;
  logic sh_done_rx;
  logic [7:0] sh_rx_byte;
  logic start_sync_tx;
  logic start_sync_rx;

  logic a_frame;
  logic [7:0] a_byte;
  logic a_stop;
  logic a_accept;
  logic tx_set;
  logic rx_set;

  // Bus handshake: every access answers on its second edge
  always_ff @(posedge i_mclk) begin
    if (i_srst)
      ack <= 1'b0;
    else
      ack <= (i_read || i_write) && !ack;
  end
  assign o_waitrequest = (i_read || i_write) && !ack;

  assign wr_ctrl = i_write && ack && i_address == CTRL_OFS
    && i_byteenable[0];
  assign wr_data = i_write && ack && i_address == DATA_OFS
    && i_byteenable[0];
  assign wr_rate = i_write && ack && i_address == RATE_OFS
    && i_byteenable[0];

  // Control fields; unsupported mode codes leave the port idle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mode <= mode_t'(CTRL_RESET[MODE_LSB +: 2]);
      multiproc_speed_select <= CTRL_RESET[SPEED_BIT];
      rx_enable <= CTRL_RESET[RXEN_BIT];
    end else if (wr_ctrl) begin
      mode <= mode_t'(i_writedata[MODE_LSB +: 2]);
      multiproc_speed_select <= i_writedata[SPEED_BIT];
      rx_enable <= i_writedata[RXEN_BIT];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst)
      rate_div32 <= RATE_RESET[DIV32_BIT];
    else if (wr_rate)
      rate_div32 <= i_writedata[DIV32_BIT];
  end

  // Reads see receive buffer, not transmit data
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (i_address)
      CTRL_OFS: begin
        next_readdata[MODE_LSB +: 2] = mode;
        next_readdata[SPEED_BIT] = multiproc_speed_select;
        next_readdata[RXEN_BIT] = rx_enable;
        next_readdata[NINTH_BIT] = rx_ninth_bit;
        next_readdata[TXDONE_BIT] = tx_done_flag;
        next_readdata[RXDONE_BIT] = rx_done_flag;
      end
      DATA_OFS: next_readdata[7:0] = serial_data_buffer;
      RATE_OFS: next_readdata[DIV32_BIT] = rate_div32;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst)
      o_readdata <= 32'h0000_0000;
    else if (i_read && !ack)
      o_readdata <= next_readdata;
  end

  // Bit tick is overflow rate, halved for divide by 32
  always_ff @(posedge i_mclk) begin
    if (i_srst)
      ovf_half <= 1'b0;
    else if (i_timer1_ovf)
      ovf_half <= !ovf_half;
  end
  assign tick = i_timer1_ovf && (!rate_div32 || ovf_half);

  // Free running transmit divider; writes wait for its rollover
  always_ff @(posedge i_mclk) begin
    if (i_srst)
      tx_cnt <= 4'h0;
    else if (tick)
      tx_cnt <= tx_cnt + 4'h1;
  end
  assign rollover = tick && tx_cnt == 4'hf;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_pend <= 1'b0;
      tx_busy <= 1'b0;
      tx_hold <= 8'h00;
      tx_sr <= 8'hff;
      tx_bits <= 4'h0;
      txd_bit <= 1'b1;
    end else if (mode != MODE_ASYNC) begin
      tx_pend <= 1'b0;
      tx_busy <= 1'b0;
      txd_bit <= 1'b1;
    end else begin
      // Writes while one is pending or before the stop bit are dropped, not queued
      if (wr_data && !tx_busy && !tx_pend) begin
        tx_pend <= 1'b1;
        tx_hold <= i_writedata[7:0];
      end
      if (rollover && tx_pend) begin
        tx_pend <= 1'b0;
        tx_busy <= 1'b1;
        tx_sr <= tx_hold;
        tx_bits <= 4'h1;
        txd_bit <= 1'b0;
      end else if (rollover && tx_busy) begin
        txd_bit <= tx_sr[0];
        tx_sr <= {1'b1, tx_sr[7:1]};
        tx_bits <= tx_bits + 4'h1;
        if (tx_bits == TX_LAST)
          tx_busy <= 1'b0;
      end
    end
  end
  // Done with the stop bit at tenth rollover
  assign tx_async_done = mode == MODE_ASYNC && rollover && tx_busy
    && tx_bits == TX_LAST;

  // Data write starts the sync shifter
  assign start_sync_tx = mode == MODE_SYNC && wr_data && !sh_busy;
  // Sync receive only when enabled and flag clear
  // Done pulse blocks the idle cycle before the flag is visible
  assign start_sync_rx = mode == MODE_SYNC && rx_enable
    && !rx_done_flag && !sh_done_rx && !sh_busy && !wr_data;

  sync_shifter u_shifter (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_speed(multiproc_speed_select),
    .i_start_tx(start_sync_tx),
    .i_start_rx(start_sync_rx),
    .i_tx_byte(i_writedata[7:0]),
    .i_rxd(i_rxd),
    .o_busy(sh_busy),
    .o_shclk(sh_clk),
    .o_data(sh_data),
    .o_data_oe(sh_oe),
    .o_done_tx(sh_done_tx),
    .o_done_rx(sh_done_rx),
    .o_rx_byte(sh_rx_byte)
  );

  async_rx u_async_rx (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_enable(mode == MODE_ASYNC && rx_enable),
    .i_tick(tick),
    .i_rxd(i_rxd),
    .o_frame(a_frame),
    .o_byte(a_byte),
    .o_stop_bit(a_stop)
  );

  // Accept only into a free buffer, with valid stop when speed bit is 1
  assign a_accept = a_frame && !rx_done_flag
    && (!multiproc_speed_select || a_stop);
  assign tx_set = sh_done_tx || tx_async_done;
  assign rx_set = sh_done_rx || a_accept;

  // Stop bit and data land together
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      serial_data_buffer <= BUF_RESET;
      rx_ninth_bit <= CTRL_RESET[NINTH_BIT];
    end else if (a_accept) begin
      serial_data_buffer <= a_byte;
      rx_ninth_bit <= a_stop;
    end else if (sh_done_rx) begin
      serial_data_buffer <= sh_rx_byte;
    end
  end

  // Sticky flags; writing 0 clears, a same-cycle set wins
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      tx_done_flag <= CTRL_RESET[TXDONE_BIT];
      rx_done_flag <= CTRL_RESET[RXDONE_BIT];
    end else begin
      if (tx_set)
        tx_done_flag <= 1'b1;
      else if (wr_ctrl && !i_writedata[TXDONE_BIT])
        tx_done_flag <= 1'b0;
      if (rx_set)
        rx_done_flag <= 1'b1;
      else if (wr_ctrl && !i_writedata[RXDONE_BIT])
        rx_done_flag <= 1'b0;
    end
  end

  // Shift clock on transmit pin in sync mode
  always_comb begin
    unique case (mode)
      MODE_SYNC: o_txd = sh_clk;
      MODE_ASYNC: o_txd = txd_bit;
      default: o_txd = 1'b1;
    endcase
  end
  assign o_rxd_out = sh_data;
  assign o_rxd_oe = mode == MODE_SYNC && sh_oe;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  sequence tx_frame_end_s;
    ##1 tx_done_flag && o_txd;
  endsequence

  bus_answer_a: assert property ((i_read || i_write) && !ack // Bus
      |=> !o_waitrequest)
    else $error("bus access not answered on second edge");
  tx_done_a: assert property (tx_async_done |-> tx_frame_end_s)
    else $error("async transmit done missing after stop bit");
  start_bit_a: assert property (mode == MODE_ASYNC && rollover
      && tx_pend && !tx_busy |=> !o_txd && tx_busy)
    else $error("start bit not driven at rollover");
  rx_keep_a: assert property (a_frame && rx_done_flag
      |=> $stable(serial_data_buffer))
    else $error("receive buffer overwritten while full");
  flag_set_wins_a: assert property (rx_set |=> rx_done_flag)
    else $error("receive done flag set lost");
  sync_halt_a: assert property (mode == MODE_SYNC && rx_done_flag
      && !sh_busy && !wr_data |=> !sh_busy)
    else $error("sync receive ran with flag set");
endmodule

// file: shared/serial_port_pkg.sv
// Shared constants, types and register map of the serial port
// How it works
// - Data register writes load transmit, reads return receive buffer.
// - Async transmit and receive paths run independently and together.
// - Sync mode: transmit pin always carries shift clock; data on receive pin.
// - Sync frames carry eight bits, least significant first, both ways.
// - Sync shift rate is clock/12 with speed bit 0, clock/4 with 1.
// - Sync mode: a data write while the shifter is idle starts the clock and shifts eight bits.
// - Fast sync: data one clock before clock falls; low for two clocks.
// - Slow sync: data three clocks before clock falls; low for six clocks.
// - Sync transmit-done flag sets the clock after the last bit ends.
// - Sync receive starts when enabled and receive-done is clear.
// - Sync receive-done sets after eighth rising edge; reception halts.
// - Async frame: start 0, eight data bits LSB first, stop 1.
// - Async bit rate is timer overflow rate over 16 or 32.
// - Async transmit bits start at divide-by-16 rollovers after a write.
// - Async transmit-done sets at the tenth rollover with the stop bit.
// - With receive enabled, watch for falling edge at sixteen times bit rate.
// - A detected falling edge resets the receive divide-by-16 counter.
// - Each bit sampled at counter states 7, 8, 9; majority decides.
// - A start bit voted 1 aborts reception and resumes edge hunting.
// - Frame accepted only if receive-done clear and speed bit 0 or stop 1.
// - Accepted frame: stop bit to ninth-bit holder, data to buffer.
// - From mid stop bit the receiver hunts for a new falling edge.
package serial_port_pkg;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] DATA_OFS = 4'h4;
  localparam logic [3:0] RATE_OFS = 4'h8;
  localparam int MODE_LSB = 6;
  localparam int SPEED_BIT = 5;
  localparam int RXEN_BIT = 4;
  localparam int NINTH_BIT = 2;
  localparam int TXDONE_BIT = 1;
  localparam int RXDONE_BIT = 0;
  localparam int DIV32_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] BUF_RESET = 8'h00;
  localparam logic [3:0] SYNC_PER_SLOW = 4'hc;
  localparam logic [3:0] SYNC_FALL_SLOW = 4'h3;
  localparam logic [3:0] SYNC_LOW_SLOW = 4'h6;
  localparam logic [3:0] SYNC_PER_FAST = 4'h4;
  localparam logic [3:0] SYNC_FALL_FAST = 4'h1;
  localparam logic [3:0] SYNC_LOW_FAST = 4'h2;
  localparam logic [3:0] VOTE_S0 = 4'h7;
  localparam logic [3:0] VOTE_S1 = 4'h8;
  localparam logic [3:0] VOTE_S2 = 4'h9;
  localparam logic [3:0] STOP_INDEX = 4'h9;
  localparam logic [3:0] TX_LAST = 4'h9;
  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_ASYNC = 2'b01,
    MODE_RSVD2 = 2'b10,
    MODE_RSVD3 = 2'b11
  } mode_t;
  typedef enum logic {
    RX_HUNT = 1'b0,
    RX_BITS = 1'b1
  } rx_state_t;
endpackage

// file: src/sync_shifter.sv
// Synchronous eight-bit shifter driving its own shift clock
`timescale 1ns/10ps
module sync_shifter import serial_port_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_speed,
  input wire logic i_start_tx,
  input wire logic i_start_rx,
  input wire logic [7:0] i_tx_byte,
  input wire logic i_rxd,
  output logic o_busy,
  output logic o_shclk,
  output logic o_data,
  output logic o_data_oe,
  output logic o_done_tx,
  output logic o_done_rx,
  output logic [7:0] o_rx_byte
);
  logic active;
  logic is_rx;
  logic [3:0] phase;
  logic [2:0] bitn;
  logic [7:0] sr;
  logic [3:0] per;
  logic [3:0] fall;
  logic [3:0] low;
  logic last;

  assign per = i_speed ? SYNC_PER_FAST : SYNC_PER_SLOW;
  assign fall = i_speed ? SYNC_FALL_FAST : SYNC_FALL_SLOW;
  assign low = i_speed ? SYNC_LOW_FAST : SYNC_LOW_SLOW;
  assign last = active && phase == per - 4'h1 && bitn == 3'h7;

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      active <= 1'b0;
      is_rx <= 1'b0;
      phase <= 4'h0;
      bitn <= 3'h0;
      sr <= 8'h00;
    end else if (!active) begin
      phase <= 4'h0;
      bitn <= 3'h0;
      if (i_start_tx) begin
        active <= 1'b1;
        is_rx <= 1'b0;
        sr <= i_tx_byte;
      end else if (i_start_rx) begin
        active <= 1'b1;
        is_rx <= 1'b1;
      end
    end else if (phase == per - 4'h1) begin
      phase <= 4'h0;
      bitn <= bitn + 3'h1;
      if (bitn == 3'h7)
        active <= 1'b0;
      if (!is_rx)
        sr <= {1'b0, sr[7:1]};
    end else begin
      phase <= phase + 4'h1;
      if (is_rx && phase == fall + low - 4'h1)
        sr <= {i_rxd, sr[7:1]};
    end
  end

  // Done one clock after frame end
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_done_tx <= 1'b0;
      o_done_rx <= 1'b0;
      o_rx_byte <= 8'h00;
    end else begin
      o_done_tx <= last && !is_rx;
      o_done_rx <= last && is_rx;
      if (last && is_rx)
        o_rx_byte <= sr;
    end
  end

  // Clock low window after data setup
  assign o_shclk = !(active && phase >= fall && phase < fall + low);
  assign o_data = sr[0];
  assign o_data_oe = active && !is_rx;
  assign o_busy = active;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  sequence low_fast_s;
    !o_shclk ##1 !o_shclk ##1 o_shclk;
  endsequence
  sequence low_slow_s;
    !o_shclk [*6] ##1 o_shclk;
  endsequence
  fast_low_a: assert property (i_speed && $fell(o_shclk) |-> low_fast_s)
    else $error("fast shift clock low time wrong");
  slow_low_a: assert property (!i_speed && $fell(o_shclk) |-> low_slow_s)
    else $error("slow shift clock low time wrong");
endmodule

// file: src/async_rx.sv
// Asynchronous ten-bit frame receiver with majority voting
`timescale 1ns/10ps
module async_rx import serial_port_pkg::*; (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_enable,
  input wire logic i_tick,
  input wire logic i_rxd,
  output logic o_frame,
  output logic [7:0] o_byte,
  output logic o_stop_bit
);
  rx_state_t state;
  logic last_rxd;
  logic [3:0] cnt;
  logic [3:0] bitn;
  logic s0;
  logic s1;
  logic vote;
  logic [7:0] sr;

  assign vote = (s0 & s1) | (s0 & i_rxd) | (s1 & i_rxd);

  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_enable) begin
      state <= RX_HUNT;
      last_rxd <= 1'b1;
      cnt <= 4'h0;
      bitn <= 4'h0;
      s0 <= 1'b1;
      s1 <= 1'b1;
      sr <= 8'h00;
    end else if (i_tick) begin
      // Edge watch at sixteen times bit rate
      last_rxd <= i_rxd;
      unique case (state)
        RX_HUNT: begin
          if (last_rxd && !i_rxd) begin
            state <= RX_BITS;
            cnt <= 4'h0;
            bitn <= 4'h0;
          end
        end
        RX_BITS: begin
          cnt <= cnt + 4'h1;
          if (cnt == VOTE_S0)
            s0 <= i_rxd;
          if (cnt == VOTE_S1)
            s1 <= i_rxd;
          if (cnt == VOTE_S2) begin
            bitn <= bitn + 4'h1;
            if (bitn == 4'h0 && vote)
              state <= RX_HUNT;
            // Hunt again from mid stop bit
            else if (bitn == STOP_INDEX)
              state <= RX_HUNT;
            else if (bitn != 4'h0)
              sr <= {vote, sr[7:1]};
          end
        end
      endcase
    end
  end

  // Frame out after stop bit vote
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_frame <= 1'b0;
      o_byte <= 8'h00;
      o_stop_bit <= 1'b0;
    end else begin
      o_frame <= i_enable && i_tick && state == RX_BITS
        && cnt == VOTE_S2 && bitn == STOP_INDEX;
      if (i_enable && i_tick && state == RX_BITS
          && cnt == VOTE_S2 && bitn == STOP_INDEX) begin
        o_byte <= sr;
        o_stop_bit <= vote;
      end
    end
  end

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  start_abort_a: assert property (i_enable && i_tick && state == RX_BITS
      && bitn == 4'h0 && cnt == VOTE_S2 && vote |=> state == RX_HUNT)
    else $error("false start bit not aborted");
  edge_align_a: assert property (i_enable && i_tick && state == RX_HUNT
      && last_rxd && !i_rxd |=> state == RX_BITS && cnt == 4'h0)
    else $error("falling edge did not realign counter");
endmodule

// file: verif/serial_partner.sv
// Far-side model: shift register peripheral and asynchronous link partner
`timescale 1ns/10ps
module serial_partner (
  input wire logic i_mclk,
  input wire logic i_sync,
  input wire logic i_shclk,
  input wire logic i_txd,
  input wire logic i_data,
  input wire logic i_data_oe,
  output logic o_line
);
  logic sh_prev = 1'b1;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] cap = 8'h00;
  int idx = 0;
  int falls = 0;
  int since_rise = 0;
  int period = 0;
  int low_cnt = 0;
  int low_len = 0;
  initial o_line = 1'b1;
  always @(posedge i_mclk) begin
    sh_prev <= i_shclk;
    since_rise <= since_rise + 1;
    if (i_sync && !i_shclk) low_cnt <= low_cnt + 1;
    if (i_sync && sh_prev && !i_shclk) begin
      falls <= falls + 1;
      // present bit at fall
      // Past the eighth bit the line toggles so stale data cannot pass
      if (!i_data_oe) begin
        o_line <= (idx < 8) ? send_byte[idx[2:0]] : ~o_line;
        idx <= idx + 1;
      end
    end
    if (i_sync && !sh_prev && i_shclk) begin
      period <= since_rise;
      since_rise <= 1;
      low_len <= low_cnt;
      low_cnt <= 0;
      if (i_data_oe) cap <= {i_data, cap[7:1]};
    end
  end
  task automatic load(input logic [7:0] b);
    send_byte = b;
    idx = 0;
  endtask
  task automatic idle();
    o_line <= 1'b1;
  endtask
  task automatic glitch(input int n);
    o_line <= 1'b0;
    repeat (n) @(posedge i_mclk);
    o_line <= 1'b1;
  endtask
  task automatic send_frame(input logic [7:0] b, input logic stop,
                            input int bclk);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_line <= f[i];
      repeat (bclk) @(posedge i_mclk);
    end
    o_line <= 1'b1;
  endtask
  task automatic get_frame(input int bclk, output logic [9:0] f);
    int n;
    n = 0;
    f = 10'h000;
    while (i_txd && n < 4000) begin
      @(posedge i_mclk);
      n++;
    end
    repeat (bclk / 2) @(posedge i_mclk);
    for (int i = 0; i < 10; i++) begin
      f[i] = i_txd;
      if (i < 9) repeat (bclk) @(posedge i_mclk);
    end
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the serial port top
`timescale 1ns/10ps
module testbench;
  import serial_port_pkg::*;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic [3:0] i_address = 4'h0;
  logic i_read = 1'b0;
  logic i_write = 1'b0;
  logic [31:0] i_writedata = 32'h0;
  logic [3:0] i_byteenable = 4'h1;
  logic i_timer1_ovf = 1'b0;
  logic sync_on = 1'b1;
  logic [31:0] o_readdata;
  logic o_waitrequest;
  logic o_txd;
  logic o_rxd_out;
  logic o_rxd_oe;
  logic line;
  logic i_rxd;
  logic [7:0] q;
  logic [9:0] fr;
  int snap;
  int err_total = 0;
  int tests_run = 0;
  assign i_rxd = o_rxd_oe ? o_rxd_out : line;
  always #12.5 i_mclk = ~i_mclk;
  // Overflow every second clock gives a 32-clock bit at divide by 16
  always @(posedge i_mclk) i_timer1_ovf <= ~i_timer1_ovf;
  serial_port DUT (.i_mclk, .i_srst, .i_address, .i_read, .i_write,
    .i_writedata, .i_byteenable, .o_readdata, .o_waitrequest,
    .i_timer1_ovf, .o_txd, .i_rxd, .o_rxd_out, .o_rxd_oe);
  serial_partner partner (.i_mclk, .i_sync(sync_on), .i_shclk(o_txd),
    .i_txd(o_txd), .i_data(o_rxd_out), .i_data_oe(o_rxd_oe),
    .o_line(line));
  task automatic test_done;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // Entered just after a rising edge; holds until waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    logic w;
    i_address <= a;
    i_writedata <= {24'h0, d};
    i_write <= wr;
    i_read <= !wr;
    n = 0;
    w = 1'b1;
    while (w && n < 20) begin
      @(posedge i_mclk);
      n++;
      // Outputs still hold their pre-edge values here
      w = o_waitrequest;
      r = o_readdata[7:0];
    end
    i_write <= 1'b0;
    i_read <= 1'b0;
    if (w) begin
      chk("bus answer", 0, 1);
      test_done;
    end
    @(posedge i_mclk);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e,
                     input string n);
    logic [7:0] v;
    bus(1'b0, a, 8'h00, v);
    chk(n, {24'h0, e}, {24'h0, v});
  endtask
  task automatic poll(input int b);
    logic [7:0] v;
    int n;
    n = 0;
    v = 8'h00;
    while (v[b] !== 1'b1 && n < 500) begin
      bus(1'b0, CTRL_OFS, 8'h00, v);
      n++;
    end
    if (n == 500) begin
      chk("flag wait", 1, 0);
      test_done;
    end
  endtask
  initial begin
    repeat (100000) @(posedge i_mclk);
    chk("run length", 0, 1);
    test_done;
  end
  initial begin
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    @(posedge i_mclk);
    rdc(CTRL_OFS, CTRL_RESET, "ctrl reset");
    rdc(RATE_OFS, RATE_RESET, "rate reset");
    rdc(4'hc, 8'h00, "unmapped read");
    bus(1'b1, CTRL_OFS, 8'h20, q);
    bus(1'b1, DATA_OFS, 8'ha5, q);
    poll(TXDONE_BIT);
    chk("fast tx byte", 8'ha5, partner.cap);
    chk("fast period", 4, partner.period);
    chk("fast low", 2, partner.low_len);
    rdc(CTRL_OFS, 8'h22, "fast flags");
    bus(1'b1, CTRL_OFS, 8'h00, q);
    bus(1'b1, DATA_OFS, 8'h4b, q);
    poll(TXDONE_BIT);
    chk("slow tx byte", 8'h4b, partner.cap);
    chk("slow period", 12, partner.period);
    chk("slow low", 6, partner.low_len);
    partner.load(8'h3c);
    bus(1'b1, CTRL_OFS, 8'h10, q);
    poll(RXDONE_BIT);
    rdc(DATA_OFS, 8'h3c, "sync rx byte");
    snap = partner.falls;
    repeat (60) @(posedge i_mclk);
    chk("rx halted", snap, partner.falls);
    rdc(CTRL_OFS, 8'h11, "sync rx flags");
    sync_on <= 1'b0;
    // Last sync bit may leave the line low: a false start otherwise
    partner.idle();
    bus(1'b1, RATE_OFS, 8'h00, q);
    bus(1'b1, CTRL_OFS, 8'h50, q);
    bus(1'b1, DATA_OFS, 8'h5a, q);
    fork
      partner.get_frame(32, fr);
      partner.send_frame(8'hc3, 1'b1, 32);
    join
    chk("async tx frame", {1'b1, 8'h5a, 1'b0}, fr);
    poll(TXDONE_BIT);
    rdc(DATA_OFS, 8'hc3, "async rx byte");
    rdc(CTRL_OFS, 8'h57, "async flags");
    partner.send_frame(8'h11, 1'b1, 32);
    rdc(DATA_OFS, 8'hc3, "frame with flag set");
    bus(1'b1, CTRL_OFS, 8'h70, q);
    partner.send_frame(8'h22, 1'b0, 32);
    rdc(CTRL_OFS, 8'h74, "bad stop dropped");
    partner.glitch(4);
    repeat (400) @(posedge i_mclk);
    rdc(CTRL_OFS, 8'h74, "false start");
    partner.send_frame(8'h96, 1'b1, 32);
    poll(RXDONE_BIT);
    rdc(DATA_OFS, 8'h96, "after abort");
    bus(1'b1, RATE_OFS, 8'h01, q);
    bus(1'b1, DATA_OFS, 8'h0f, q);
    partner.get_frame(64, fr);
    chk("div32 frame", {1'b1, 8'h0f, 1'b0}, fr);
    rdc(RATE_OFS, 8'h01, "rate readback");
    test_done;
  end
endmodule
